// ===== csir_params.svh
// Constants for the core status and interrupt control register bank
`ifndef CSIR_PARAMS_SVH
`define CSIR_PARAMS_SVH
`define CSIR_ADDR_STATUS 1'h0
`define CSIR_ADDR_INTCTL 1'h1
`define CSIR_BIT_HIGH_BANK 7
`define CSIR_BIT_RES_BANK 6
`define CSIR_BIT_BANK 5
`define CSIR_BIT_WDT_N 4
`define CSIR_BIT_PD_N 3
`define CSIR_BIT_ZERO 2
`define CSIR_BIT_DC 1
`define CSIR_BIT_CARRY 0
`define CSIR_BIT_GIE 7
`define CSIR_BIT_PERIPHERAL_GROUP_ENABLE 6
`define CSIR_BIT_TIMER0_OVERFLOW_ENABLE 5
`define CSIR_BIT_EIE 4
`define CSIR_BIT_GCIE 3
`define CSIR_BIT_TIMER0_OVERFLOW_FLAG 2
`define CSIR_BIT_EIF 1
`define CSIR_BIT_GCIF 0
`define CSIR_STATUS_RESET 8'h18
`define CSIR_INTCTL_RESET 8'h00
`define CSIR_PIN_COUNT 6
`endif

// ===== csir_pkg.sv
// Types for the core status and interrupt control register bank
package csir_pkg;
    typedef enum logic [5:0] {
        CSIR_OP_NONE = 6'h01,
        CSIR_OP_ADD = 6'h02,
        CSIR_OP_SUB = 6'h04,
        CSIR_OP_LOGIC = 6'h08,
        CSIR_OP_ROT_LEFT = 6'h10,
        CSIR_OP_ROT_RIGHT = 6'h20
    } csir_op_type;
endpackage

// ===== csir_core_regs.sv
// Core status register and interrupt control register with flag logic
//
// Summary of operation
// - Flag-updating op targeting status: data write to Z, DC, C blocked.
// - Writes to time-out and power-down bits are ignored.
// - Clear instruction on status clears top three bits, sets Z.
// - Bank select bit 5 steers direct addressing; resets to zero.
// - Time-out bit set at power-up, watchdog clear, sleep; cleared on expiry.
// - Power-down bit set at power-up, watchdog clear; cleared by sleep.
// - Zero flag set when an add, subtract or logic result is zero, cleared otherwise.
// - Digit carry from bit 3 into bit 4; inverted borrow for subtract.
// - Carry from most significant bit; inverted borrow for subtract.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out.
// - Interrupt flags set regardless of the control register enable bits.
// - Bit 7 global enable gates every interrupt.
// - Bit 6 gates the peripheral interrupt group.
// - Bits 5, 4, 3 enable timer0, edge pin and pin change sources.
// - Timer0 flag set on rollover, held until software clears it.
// - Edge pin flag set on edge event, held until cleared.
// - Pin change flag set when an enabled pin changes, held until cleared.
// - Only pins enabled in the per-pin change mask contribute.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csir_params.svh"

module csir_core_regs #(
    parameter int PIN_COUNT = `CSIR_PIN_COUNT
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic ALU_VALID_I,
    input wire csir_pkg::csir_op_type ALU_OP_I,
    input wire logic [7:0] ALU_A_I,
    input wire logic [7:0] ALU_B_I,
    output logic [7:0] ALU_RESULT_O,
    input wire logic CLEAR_STATUS_I,
    input wire logic WATCHDOG_CLEAR_INSTR_I,
    input wire logic SLEEP_INSTR_I,
    input wire logic WATCHDOG_EXPIRED_I,
    input wire logic TIMER0_ROLLOVER_I,
    input wire logic EXTERNAL_EDGE_PIN_I,
    input wire logic EDGE_RISING_I,
    input wire logic PERIPH_IRQ_I,
    input wire logic [PIN_COUNT-1:0] GPIO_PINS_I,
    input wire logic [PIN_COUNT-1:0] PER_PIN_CHANGE_ENABLE_I,
    output logic BANK_SELECT_O,
    output logic IRQ_O
);
    import csir_pkg::*;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] intctl;
        logic [7:0] rdata;
        logic [7:0] result;
        logic irq;
        logic [1:0] edge_sync;
        logic edge_prev;
        logic [PIN_COUNT-1:0] pin_s1;
        logic [PIN_COUNT-1:0] pin_s2;
        logic [PIN_COUNT-1:0] pin_prev;
        logic [2:0] primed;
    } csir_state_type;

    csir_state_type st_q;
    csir_state_type st_d;

    logic [8:0] sum;
    logic [4:0] nib_sum;
    logic [7:0] opnd_b;
    logic cin;
    logic edge_event;
    logic [PIN_COUNT-1:0] pin_change;
    logic irq_req;

    // Adder shared by add and subtract; subtract feeds inverted B plus one
    always_comb
    begin
        opnd_b = (ALU_OP_I == CSIR_OP_SUB) ? ~ALU_B_I : ALU_B_I;
        cin = (ALU_OP_I == CSIR_OP_SUB);
        sum = {1'b0, ALU_A_I} + {1'b0, opnd_b} + {8'h00, cin};
        nib_sum = {1'b0, ALU_A_I[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
    end

    // Edge and pin change detection on synchronised copies only; the compare
    // copies hold real pin levels only from the third edge after reset, so a
    // pin that idles high cannot fake an event before then
    assign edge_event = st_q.primed[2] && (st_q.edge_sync[1] != st_q.edge_prev)
        && (st_q.edge_sync[1] == EDGE_RISING_I);
    assign pin_change = st_q.primed[2] ? ((st_q.pin_s2 ^ st_q.pin_prev) & PER_PIN_CHANGE_ENABLE_I)
        : {PIN_COUNT{1'b0}};

    // Request needs global enable; peripheral sources also need group enable
    assign irq_req = st_d.intctl[`CSIR_BIT_GIE]
        && ((st_d.intctl[`CSIR_BIT_TIMER0_OVERFLOW_ENABLE] && st_d.intctl[`CSIR_BIT_TIMER0_OVERFLOW_FLAG])
        || (st_d.intctl[`CSIR_BIT_EIE] && st_d.intctl[`CSIR_BIT_EIF])
        || (st_d.intctl[`CSIR_BIT_GCIE] && st_d.intctl[`CSIR_BIT_GCIF])
        || (st_d.intctl[`CSIR_BIT_PERIPHERAL_GROUP_ENABLE] && PERIPH_IRQ_I));

    // Next-state logic: bus write first, then hardware updates override
    always_comb
    begin
        st_d = st_q;
        st_d.edge_sync = {st_q.edge_sync[0], EXTERNAL_EDGE_PIN_I};
        st_d.edge_prev = st_q.edge_sync[1];
        st_d.pin_s1 = GPIO_PINS_I;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_prev = st_q.pin_s2;
        st_d.primed = {st_q.primed[1:0], 1'b1};
        // Software write: time-out and power-down bits kept from hardware
        if (WR_I && ADDR_I == `CSIR_ADDR_STATUS)
        begin
            st_d.status[7:5] = WDATA_I[7:5];
            // A flag-updating op in the same cycle blocks the write to Z, DC, C
            if (!(ALU_VALID_I && ALU_OP_I != CSIR_OP_NONE))
            begin
                st_d.status[2:0] = WDATA_I[2:0];
            end
        end
        else if (WR_I && ADDR_I == `CSIR_ADDR_INTCTL)
        begin
            st_d.intctl = WDATA_I;
        end
        // Clear instruction: zero upper three bits, set zero flag
        if (CLEAR_STATUS_I)
        begin
            st_d.status[7:5] = 3'h0;
            st_d.status[`CSIR_BIT_ZERO] = 1'b1;
        end
        // Flag results replace any data written to the low three bits
        if (ALU_VALID_I && ALU_OP_I != CSIR_OP_NONE)
        begin
            case (ALU_OP_I)
                CSIR_OP_ADD, CSIR_OP_SUB:
                begin
                    st_d.result = sum[7:0];
                    st_d.status[`CSIR_BIT_ZERO] = (sum[7:0] == 8'h00);
                    st_d.status[`CSIR_BIT_DC] = nib_sum[4];
                    st_d.status[`CSIR_BIT_CARRY] = sum[8];
                end
                CSIR_OP_LOGIC:
                begin
                    st_d.result = ALU_A_I & ALU_B_I;
                    st_d.status[`CSIR_BIT_ZERO] = ((ALU_A_I & ALU_B_I) == 8'h00);
                end
                CSIR_OP_ROT_LEFT:
                begin
                    st_d.result = {ALU_A_I[6:0], st_q.status[`CSIR_BIT_CARRY]};
                    st_d.status[`CSIR_BIT_CARRY] = ALU_A_I[7];
                end
                CSIR_OP_ROT_RIGHT:
                begin
                    st_d.result = {st_q.status[`CSIR_BIT_CARRY], ALU_A_I[7:1]};
                    st_d.status[`CSIR_BIT_CARRY] = ALU_A_I[0];
                end
                default:
                begin
                    st_d.result = st_q.result;
                end
            endcase
        end
        // Reset-cause bits; expiry wins over a same-cycle clear or sleep
        if (WATCHDOG_CLEAR_INSTR_I)
        begin
            st_d.status[`CSIR_BIT_WDT_N] = 1'b1;
            st_d.status[`CSIR_BIT_PD_N] = 1'b1;
        end
        if (SLEEP_INSTR_I)
        begin
            st_d.status[`CSIR_BIT_WDT_N] = 1'b1;
            st_d.status[`CSIR_BIT_PD_N] = 1'b0;
        end
        if (WATCHDOG_EXPIRED_I)
        begin
            st_d.status[`CSIR_BIT_WDT_N] = 1'b0;
        end
        // Event sets come last so a set beats a same-cycle software clear
        if (TIMER0_ROLLOVER_I)
        begin
            st_d.intctl[`CSIR_BIT_TIMER0_OVERFLOW_FLAG] = 1'b1;
        end
        if (edge_event)
        begin
            st_d.intctl[`CSIR_BIT_EIF] = 1'b1;
        end
        if (|pin_change)
        begin
            st_d.intctl[`CSIR_BIT_GCIF] = 1'b1;
        end
        // Read data stand in the cycle after the strobe only
        if (RD_I)
        begin
            if (ADDR_I == `CSIR_ADDR_STATUS)
            begin
                st_d.rdata = st_q.status;
            end
            else
            begin
                st_d.rdata = st_q.intctl;
            end
        end
        else
        begin
            st_d.rdata = 8'h00;
        end
    end

    // Fold the request into the registered state
    csir_state_type st_n;
    always_comb
    begin
        st_n = st_d;
        st_n.irq = irq_req;
    end

    // Single state register; status bits 4 and 3 read one after power-on
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            st_q <= '0;
            st_q.status <= `CSIR_STATUS_RESET;
            st_q.intctl <= `CSIR_INTCTL_RESET;
        end
        else
        begin
            st_q <= st_n;
        end
    end

    assign RDATA_O = st_q.rdata;
    assign ALU_RESULT_O = st_q.result;
    assign BANK_SELECT_O = st_q.status[`CSIR_BIT_BANK];
    assign IRQ_O = st_q.irq;

    // Reference sums built apart from the shared adder, so the checks below
    // do not simply repeat the datapath they guard
    logic [8:0] ref_add;
    logic [4:0] ref_add_nib;
    assign ref_add = {1'b0, ALU_A_I} + {1'b0, ALU_B_I};
    assign ref_add_nib = {1'b0, ALU_A_I[3:0]} + {1'b0, ALU_B_I[3:0]};

    // Write to status never moves the reset-cause bits
    property p_cause_bits_write;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (WR_I && ADDR_I == `CSIR_ADDR_STATUS && !WATCHDOG_CLEAR_INSTR_I && !SLEEP_INSTR_I
        && !WATCHDOG_EXPIRED_I) |=> $stable(st_q.status[4:3]);
    endproperty
    a_cause_bits_write: assert property (p_cause_bits_write) else $error("cause bits written");

    property p_clear_status;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (CLEAR_STATUS_I && !(ALU_VALID_I && ALU_OP_I != CSIR_OP_NONE))
        |=> (st_q.status[7:5] == 3'h0) && st_q.status[2];
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("clear did not act");

    property p_bank_out;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (WR_I && ADDR_I == `CSIR_ADDR_STATUS && !CLEAR_STATUS_I) |=> BANK_SELECT_O == $past(WDATA_I[5]);
    endproperty
    a_bank_out: assert property (p_bank_out) else $error("bank select wrong");

    property p_sleep;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (SLEEP_INSTR_I && !WATCHDOG_EXPIRED_I) |=> !st_q.status[3] && st_q.status[4];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep bits wrong");

    property p_expiry;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        WATCHDOG_EXPIRED_I |=> !st_q.status[4];
    endproperty
    a_expiry: assert property (p_expiry) else $error("time-out not cleared");

    property p_add_flags;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (ALU_VALID_I && ALU_OP_I == CSIR_OP_ADD) |=> (st_q.status[0] == $past(ref_add[8]))
        && (st_q.status[1] == $past(ref_add_nib[4]))
        && (st_q.status[2] == ($past(ref_add[7:0]) == 8'h00)) && (ALU_RESULT_O == $past(ref_add[7:0]));
    endproperty
    a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

    property p_timer_flag;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        TIMER0_ROLLOVER_I |=> st_q.intctl[2];
    endproperty
    a_timer_flag: assert property (p_timer_flag) else $error("timer flag lost");

    property p_irq_gate;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        !st_q.intctl[7] |-> !IRQ_O;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without global enable");

    // Carry set means no borrow: a carry out of A plus not-B plus one
    property p_sub_flags;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (ALU_VALID_I && ALU_OP_I == CSIR_OP_SUB)
        |=> (st_q.status[0] == ($past(ALU_A_I) >= $past(ALU_B_I)))
        && (st_q.status[1] == ($past(ALU_A_I[3:0]) >= $past(ALU_B_I[3:0])))
        && (ALU_RESULT_O == 8'($past(ALU_A_I) - $past(ALU_B_I)));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract borrow flags wrong");

    // Rotates move only the carry; zero and digit carry keep their values
    property p_rot_left;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (ALU_VALID_I && ALU_OP_I == CSIR_OP_ROT_LEFT && !CLEAR_STATUS_I)
        |=> (st_q.status[0] == $past(ALU_A_I[7])) && (ALU_RESULT_O[7:1] == $past(ALU_A_I[6:0]))
        && $stable(st_q.status[2:1]);
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left carry wrong");

    property p_rot_right;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (ALU_VALID_I && ALU_OP_I == CSIR_OP_ROT_RIGHT && !CLEAR_STATUS_I)
        |=> (st_q.status[0] == $past(ALU_A_I[0])) && (ALU_RESULT_O[6:0] == $past(ALU_A_I[7:1]))
        && $stable(st_q.status[2:1]);
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("rotate right carry wrong");

    // Logic ops touch only the zero flag, even with a status write beside them
    property p_logic_zero;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (ALU_VALID_I && ALU_OP_I == CSIR_OP_LOGIC)
        |=> (ALU_RESULT_O == ($past(ALU_A_I) & $past(ALU_B_I)))
        && (st_q.status[2] == (ALU_RESULT_O == 8'h00)) && $stable(st_q.status[1:0]);
    endproperty
    a_logic_zero: assert property (p_logic_zero) else $error("logic flags wrong");

    property p_edge_flag;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        edge_event |=> st_q.intctl[1];
    endproperty
    a_edge_flag: assert property (p_edge_flag) else $error("edge flag lost");

    property p_pin_flag;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (|pin_change) |=> st_q.intctl[0];
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin change flag lost");

    // Any enabled core flag under global enable must raise the request
    property p_irq_source;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (st_q.intctl[7] && ((st_q.intctl[5] && st_q.intctl[2]) || (st_q.intctl[4] && st_q.intctl[1])
        || (st_q.intctl[3] && st_q.intctl[0]))) |-> IRQ_O;
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("enabled flag gave no request");
endmodule
`default_nettype wire

// ===== csir_event_model.sv
// Behavioural source of timer, edge-pin and pin-change events
`timescale 1ns/1ps
`default_nettype none
module csir_event_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] kind_i,
    input wire logic [5:0] sel_i,
    output logic roll_o,
    output logic edge_o,
    output logic [5:0] pins_o
);
    // Command 1 pulses a rollover, 2 toggles the edge pin, 3 toggles selected pins
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            roll_o <= 1'b0;
            edge_o <= 1'b0;
            pins_o <= 6'h00;
        end
        else
        begin
            roll_o <= (kind_i == 2'h1);
            edge_o <= edge_o ^ (kind_i == 2'h2);
            pins_o <= pins_o ^ ((kind_i == 2'h3) ? sel_i : 6'h00);
        end
    end
endmodule
`default_nettype wire

// ===== csir_core_regs_bench.sv
// Self-checking bench for the status and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module csir_core_regs_bench;
    import csir_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic addr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rd_p = 1'b0;
    logic alu_v = 1'b0;
    csir_op_type alu_op = CSIR_OP_NONE;
    logic [7:0] alu_a = 8'h00;
    logic [7:0] alu_b = 8'h00;
    logic [3:0] pul = 4'h0;
    logic [1:0] kind = 2'h0;
    logic [5:0] sel = 6'h00;
    logic [5:0] mask = 6'h00;
    logic periph = 1'b0;
    logic rising = 1'b1;
    logic [7:0] rdata, alu_res, st;
    logic roll, edge_pin, bank, irq;
    logic [5:0] pins;
    logic [7:0] expq [$];
    csir_op_type ops [5] = '{CSIR_OP_ADD, CSIR_OP_SUB, CSIR_OP_LOGIC, CSIR_OP_ROT_LEFT, CSIR_OP_ROT_RIGHT};
    logic [3:0] wp [3] = '{4'h8, 4'h4, 4'h2};
    logic [1:0] wx [3] = '{2'h1, 2'h2, 2'h3};
    int num_errors = 0;
    int compares = 0;
    // Free-running core clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    csir_core_regs csir_core_regs_i (.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .ALU_VALID_I(alu_v), .ALU_OP_I(alu_op),
        .ALU_A_I(alu_a), .ALU_B_I(alu_b), .ALU_RESULT_O(alu_res), .CLEAR_STATUS_I(pul[0]),
        .WATCHDOG_CLEAR_INSTR_I(pul[1]), .SLEEP_INSTR_I(pul[2]), .WATCHDOG_EXPIRED_I(pul[3]),
        .TIMER0_ROLLOVER_I(roll), .EXTERNAL_EDGE_PIN_I(edge_pin), .EDGE_RISING_I(rising),
        .PERIPH_IRQ_I(periph), .GPIO_PINS_I(pins), .PER_PIN_CHANGE_ENABLE_I(mask),
        .BANK_SELECT_O(bank), .IRQ_O(irq));
    csir_event_model csir_event_model_i (.clk_i(clk), .nrst_i(nrst), .kind_i(kind), .sel_i(sel),
        .roll_o(roll), .edge_o(edge_pin), .pins_o(pins));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe, so compare there
    always @(posedge clk)
        rd_p <= rd_s;
    always @(negedge clk)
    begin
        if (rd_p && expq.size() > 0)
            chk(rdata, expq.pop_front());
    end
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        if (!a)
            st = {d[7:5], st[4:3], d[2:0]};
    endtask
    task automatic rd(input logic a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd_s <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        pul <= v;
        @(posedge clk);
        pul <= 4'h0;
    endtask
    // Pins pass two sync flops, so leave time before looking at flags
    task automatic ev(input logic [1:0] k, input logic [5:0] s);
        @(posedge clk);
        kind <= k;
        sel <= s;
        @(posedge clk);
        kind <= 2'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic lvl(input bit which, input logic e);
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, which ? irq : bank}, {7'h00, e});
    endtask
    // Flag model: a status write in the same cycle carries inverted flags
    task automatic alu(input csir_op_type op, input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        logic sub;
        sub = (op == CSIR_OP_SUB);
        s = {1'b0, a} + {1'b0, sub ? ~b : b} + 9'(sub);
        h = {1'b0, a[3:0]} + {1'b0, sub ? ~b[3:0] : b[3:0]} + 5'(sub);
        r = s[7:0];
        if (op == CSIR_OP_LOGIC)
            r = a & b;
        if (op == CSIR_OP_ROT_LEFT || op == CSIR_OP_ROT_RIGHT)
            r = (op == CSIR_OP_ROT_LEFT) ? {a[6:0], st[0]} : {st[0], a[7:1]};
        if (op == CSIR_OP_LOGIC)
            st[2] = (r == 8'h00);
        else if (op == CSIR_OP_ROT_LEFT || op == CSIR_OP_ROT_RIGHT)
            st[0] = (op == CSIR_OP_ROT_LEFT) ? a[7] : a[0];
        else
            st[2:0] = {r == 8'h00, h[4], s[8]};
        @(posedge clk);
        alu_v <= 1'b1;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        addr <= 1'b0;
        wdata <= {st[7:5], 2'b00, ~st[2:0]};
        wr_s <= 1'b1;
        @(posedge clk);
        alu_v <= 1'b0;
        wr_s <= 1'b0;
        #1;
        chk(alu_res, r);
    endtask
    // Main sequence
    initial
    begin
        logic [7:0] a;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        void'($urandom(32'hA496));
        st = 8'h18;
        rd(1'b0, 8'h18);
        rd(1'b1, 8'h00);
        lvl(1'b0, 1'b0);
        wr(1'b0, 8'h00);
        rd(1'b0, st);
        wr(1'b0, 8'h23);
        rd(1'b0, st);
        lvl(1'b0, 1'b1);
        pulse(4'h1);
        st = {3'b000, st[4:3], 1'b1, st[1:0]};
        rd(1'b0, st);
        lvl(1'b0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            pulse(wp[i]);
            st[4:3] = wx[i];
            rd(1'b0, st);
        end
        $display("status access test done");
        for (int i = 0; i < 20; i++)
        begin
            a = 8'($urandom);
            alu(ops[i % 5], a, (i < 5) ? 8'(-a) : 8'($urandom));
            rd(1'b0, st);
        end
        $display("flag update test done");
        wr(1'b1, 8'h00);
        ev(2'h1, 6'h00);
        rd(1'b1, 8'h04);
        lvl(1'b1, 1'b0);
        wr(1'b1, 8'hA4);
        lvl(1'b1, 1'b1);
        wr(1'b1, 8'h24);
        lvl(1'b1, 1'b0);
        wr(1'b1, 8'h00);
        ev(2'h2, 6'h00);
        rd(1'b1, 8'h02);
        wr(1'b1, 8'h00);
        ev(2'h2, 6'h00);
        rd(1'b1, 8'h00);
        rising <= 1'b0;
        ev(2'h2, 6'h00);
        rd(1'b1, 8'h00);
        ev(2'h2, 6'h00);
        rd(1'b1, 8'h02);
        wr(1'b1, 8'h00);
        mask <= 6'h04;
        ev(2'h3, 6'h01);
        rd(1'b1, 8'h00);
        ev(2'h3, 6'h04);
        rd(1'b1, 8'h01);
        wr(1'b1, 8'h89);
        lvl(1'b1, 1'b1);
        wr(1'b1, 8'h81);
        lvl(1'b1, 1'b0);
        periph <= 1'b1;
        lvl(1'b1, 1'b0);
        wr(1'b1, 8'hC0);
        lvl(1'b1, 1'b1);
        $display("interrupt test done");
        repeat (3) @(posedge clk);
        summarize();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
